/* peripheral_interrupt_prioritizer.sv */
// Peripheral interrupt prioritizer: priority registers, arbitration, event codes, APB slave
module peripheral_interrupt_prioritizer #(
   parameter int ADDR_W = 8
) (
   input  wire logic                                  clock_i,
   input  wire logic                                  rst_i,
   // APB slave
   input  wire logic                                  psel_i,
   input  wire logic                                  penable_i,
   input  wire logic                                  pwrite_i,
   input  wire logic [ADDR_W-1:0]                     paddr_i,
   input  wire logic [31:0]                           pwdata_i,
   output logic      [31:0]                           prdata_o,
   output logic                                       pready_o,
   output logic                                       pslverr_o,
   // Requests from peripherals and pin detectors, same clock
   input  wire logic [prioritizer_pkg::NUM_SRC-1:0]   src_req_i,
   input  wire logic                                  nmi_req_i,
   // CPU core side
   input  wire logic [3:0]                            cpu_mask_level_i,
   input  wire logic                                  cpu_standby_i,
   input  wire logic                                  cpu_accept_i,
   output logic                                       cpu_irq_req_o,
   output logic      [prioritizer_pkg::LVL_W-1:0]     cpu_irq_level_o,
   output logic                                       standby_wake_o,
   output logic                                       irq_o
);

   localparam int NS = prioritizer_pkg::NUM_SRC;
   localparam int LW = prioritizer_pkg::LVL_W;
   localparam int CW = prioritizer_pkg::CODE_W;
   localparam int EW = prioritizer_pkg::EV_W;

   // Refused at elaboration: the map reaches 0x28 and needs six address bits
   if (ADDR_W < 6) begin : g_addr_chk
      $error("ADDR_W too small for the register map");
   end

   // Primary code of a level-coded source
   function automatic logic [CW-1:0] level_code(input logic [3:0] lvl);
      logic [3:0] inv;
      inv = 4'hF - lvl;
      return prioritizer_pkg::CODE_LBASE + CW'(inv) * prioritizer_pkg::CODE_LSTEP;
   endfunction

   // Priority field lookup
   function automatic logic [3:0] field_of(input logic [15:0] pri [prioritizer_pkg::NUM_PRI],
                                           input logic [prioritizer_pkg::FIELD_W-1:0] f);
      logic [2:0] r;
      logic [1:0] n;
      r = 3'(f >> 2);
      n = f[1:0];
      return pri[r][n*4 +: 4];
   endfunction

   logic [15:0]  pri_reg          [prioritizer_pkg::NUM_PRI];
   logic [CW-1:0] event_code_reg;
   logic [CW-1:0] event_code_fixed_reg;
   logic [EW-1:0] int_stat_reg;
   logic [EW-1:0] int_en_reg;
   logic          osc32k_reg;
   logic [31:0]   prdata_reg;
   logic          req_reg;
   logic [LW-1:0] lvl_reg;
   logic [CW-1:0] win_code_reg;
   logic [CW-1:0] win_fixed_reg;
   logic          wake_reg;

   // APB decode
   wire              setup_ph  = psel_i & ~penable_i;
   wire              wr_acc    = psel_i & penable_i & pwrite_i;
   wire [7:0]        addr8     = 8'(paddr_i);
   wire              word_ok   = (paddr_i[1:0] == 2'b00) && (paddr_i >> 8 == '0);
   wire              hit_pri   = word_ok && addr8 <= prioritizer_pkg::ADDR_PRI_E;
   wire [2:0]        pri_idx   = 3'(addr8 >> 2);
   wire              hit_ev    = word_ok && addr8 == prioritizer_pkg::ADDR_EVENT;
   wire              hit_evf   = word_ok && addr8 == prioritizer_pkg::ADDR_EVENT_FIX;
   wire              hit_stat  = word_ok && addr8 == prioritizer_pkg::ADDR_INT_STAT;
   wire              hit_en    = word_ok && addr8 == prioritizer_pkg::ADDR_INT_EN;
   wire              hit_clr   = word_ok && addr8 == prioritizer_pkg::ADDR_INT_CLR;
   wire              hit_ctrl  = word_ok && addr8 == prioritizer_pkg::ADDR_CTRL;
   wire              mapped    = hit_pri | hit_ev | hit_evf | hit_stat | hit_en | hit_clr
                                 | hit_ctrl;
   // Read-only registers refuse writes; clear register is write-only
   wire              bad_wr    = pwrite_i & (hit_ev | hit_evf | hit_stat);
   wire              bad_rd    = ~pwrite_i & hit_clr;
   wire              err       = ~mapped | bad_wr | bad_rd;
   wire              wr_ok     = wr_acc & ~err;

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_pri) begin
         rd_mux = {16'h0000, pri_reg[pri_idx]};
      end else if (hit_ev) begin
         rd_mux = 32'(event_code_reg);
      end else if (hit_evf) begin
         rd_mux = 32'(event_code_fixed_reg);
      end else if (hit_stat) begin
         rd_mux = 32'(int_stat_reg);
      end else if (hit_en) begin
         rd_mux = 32'(int_en_reg);
      end else if (hit_ctrl) begin
         rd_mux = 32'(osc32k_reg);
      end
   end

   assign pready_o  = psel_i & penable_i;
   assign pslverr_o = psel_i & penable_i & err;
   assign prdata_o  = prdata_reg;

   // Level of each source
   logic [LW-1:0] src_lvl [NS];
   always_comb begin
      for (int i = 0; i < NS; i++) begin
         src_lvl[i] = LW'(field_of(pri_reg, prioritizer_pkg::SRC_FIELD[i]));
      end
      src_lvl[prioritizer_pkg::SRC_DEBUG] = prioritizer_pkg::LVL_DEBUG;
   end

   // Arbitration: strict compare keeps the earliest source on a tie
   logic [LW-1:0]  best_lvl;
   logic [5:0]     best_idx;
   logic [CW-1:0]  best_code;
   logic [CW-1:0]  best_fixed;
   logic           wake_any;
   always_comb begin
      best_lvl   = prioritizer_pkg::LVL_NONE;
      best_idx   = 6'h00;
      wake_any   = 1'b0;
      for (int i = 0; i < NS; i++) begin
         if (src_req_i[i] && src_lvl[i] > best_lvl) begin
            best_lvl = src_lvl[i];
            best_idx = 6'(i);
         end
         if (i >= prioritizer_pkg::SRC_WAKE_LO && i <= prioritizer_pkg::SRC_WAKE_HI
             && src_req_i[i] && src_lvl[i] > LW'(cpu_mask_level_i)) begin
            wake_any = 1'b1;
         end
      end
      best_fixed = prioritizer_pkg::FIXED_CODE[best_idx];
      best_code  = prioritizer_pkg::LEVEL_CODED[best_idx]
                   ? level_code(best_lvl[3:0]) : best_fixed;
      if (nmi_req_i) begin
         best_lvl   = prioritizer_pkg::LVL_NMI;
         best_code  = prioritizer_pkg::CODE_NMI;
         best_fixed = prioritizer_pkg::CODE_NMI;
      end
   end

   // Level 0 never wins, so best_lvl above the mask implies a real request
   wire req_now  = best_lvl > LW'(cpu_mask_level_i);
   wire wake_now = wake_any & osc32k_reg & cpu_standby_i;
   wire accept   = cpu_accept_i & req_reg;

   wire [EW-1:0] ev_set = {wake_now & ~wake_reg, accept};
   wire [EW-1:0] ev_clr = (wr_ok && hit_clr) ? pwdata_i[EW-1:0] : '0;

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         for (int r = 0; r < prioritizer_pkg::NUM_PRI; r++) begin
            pri_reg[r] <= {4{prioritizer_pkg::PRI_RESET}};
         end
      end else if (wr_ok && hit_pri) begin
         pri_reg[pri_idx] <= pwdata_i[15:0] & prioritizer_pkg::PRI_WMASK[pri_idx];
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         req_reg       <= 1'b0;
         lvl_reg       <= prioritizer_pkg::LVL_NONE;
         win_code_reg  <= prioritizer_pkg::CODE_NONE;
         win_fixed_reg <= prioritizer_pkg::CODE_NONE;
         wake_reg      <= 1'b0;
      end else begin
         req_reg       <= req_now;
         lvl_reg       <= req_now ? best_lvl : prioritizer_pkg::LVL_NONE;
         win_code_reg  <= best_code;
         win_fixed_reg <= best_fixed;
         wake_reg      <= wake_now;
      end
   end

   // Only the codes are loaded; the CPU keeps its own mask bits untouched
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         event_code_reg       <= prioritizer_pkg::CODE_NONE;
         event_code_fixed_reg <= prioritizer_pkg::CODE_NONE;
      end else if (accept) begin
         event_code_reg       <= win_code_reg;
         event_code_fixed_reg <= win_fixed_reg;
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         int_stat_reg <= '0;
         int_en_reg   <= '0;
         osc32k_reg   <= 1'b0;
      end else begin
         int_stat_reg <= (int_stat_reg & ~ev_clr) | ev_set;
         if (wr_ok && hit_en) begin
            int_en_reg <= pwdata_i[EW-1:0];
         end
         if (wr_ok && hit_ctrl) begin
            osc32k_reg <= pwdata_i[prioritizer_pkg::CTRL_OSC32K];
         end
      end
   end

   // Read data captured in the setup cycle so it comes from a flip-flop
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup_ph && !pwrite_i) begin
         prdata_reg <= rd_mux;
      end
   end

   assign cpu_irq_req_o   = req_reg;
   assign cpu_irq_level_o = lvl_reg;
   assign standby_wake_o  = wake_reg;
   assign irq_o           = |(int_stat_reg & int_en_reg);

endmodule // peripheral_interrupt_prioritizer

/* prioritizer_pkg.sv */
// Package of constants, source table and register map for the interrupt prioritizer
package prioritizer_pkg;

   localparam int NUM_SRC    = 36;
   localparam int NUM_PRI    = 5;
   localparam int NUM_FIELD  = 20;
   localparam int SRC_W      = 6;
   localparam int FIELD_W    = 5;
   localparam int LVL_W      = 5;
   localparam int CODE_W     = 12;

   // Levels
   localparam logic [LVL_W-1:0]  LVL_NONE   = 5'h00;
   localparam logic [LVL_W-1:0]  LVL_DEBUG  = 5'h0F;
   localparam logic [LVL_W-1:0]  LVL_NMI    = 5'h10;
   localparam logic [3:0]        PRI_RESET  = 4'h0;

   // Event codes
   localparam logic [CODE_W-1:0] CODE_NMI   = 12'h1C0;
   localparam logic [CODE_W-1:0] CODE_LBASE = 12'h200;
   localparam logic [CODE_W-1:0] CODE_LSTEP = 12'h020;
   localparam logic [CODE_W-1:0] CODE_NONE  = 12'h000;

   // Source order is the default order, index 0 ranks highest
   localparam int SRC_DEBUG  = 0;
   localparam int SRC_WAKE_LO = 22;
   localparam int SRC_WAKE_HI = 28;

   localparam logic [CODE_W-1:0] FIXED_CODE [NUM_SRC] = '{
      12'h5E0,
      12'h600, 12'h620, 12'h640, 12'h660, 12'h680, 12'h6A0,
      12'h700, 12'h720,
      12'h800, 12'h820, 12'h840, 12'h860,
      12'h880, 12'h8A0, 12'h8C0, 12'h8E0,
      12'h900, 12'h920, 12'h940, 12'h960,
      12'h980,
      12'h400, 12'h420, 12'h440, 12'h460,
      12'h480, 12'h4A0, 12'h4C0,
      12'h4E0, 12'h500, 12'h520, 12'h540,
      12'h560,
      12'h580, 12'h5A0
   };

   // Field number = register index * 4 + nibble, nibble 0 being bits 3-0
   localparam logic [FIELD_W-1:0] SRC_FIELD [NUM_SRC] = '{
      5'h00,
      5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
      5'h0F, 5'h0E,
      5'h13, 5'h13, 5'h13, 5'h13,
      5'h12, 5'h12, 5'h12, 5'h12,
      5'h11, 5'h11, 5'h11, 5'h11,
      5'h10,
      5'h03, 5'h02, 5'h01, 5'h01,
      5'h00, 5'h00, 5'h00,
      5'h05, 5'h05, 5'h05, 5'h05,
      5'h07,
      5'h06, 5'h06
   };

   // Sources whose primary code follows the level (bit i = source i)
   localparam logic [NUM_SRC-1:0] LEVEL_CODED = 36'h0003FFFFE;

   // Register map, byte addresses
   localparam logic [7:0] ADDR_PRI_A      = 8'h00;
   localparam logic [7:0] ADDR_PRI_E      = 8'h10;
   localparam logic [7:0] ADDR_EVENT      = 8'h14;
   localparam logic [7:0] ADDR_EVENT_FIX  = 8'h18;
   localparam logic [7:0] ADDR_INT_STAT   = 8'h1C;
   localparam logic [7:0] ADDR_INT_EN     = 8'h20;
   localparam logic [7:0] ADDR_INT_CLR    = 8'h24;
   localparam logic [7:0] ADDR_CTRL       = 8'h28;

   // Writable bits of each priority register; register B bits 3-0 reserved
   localparam logic [15:0] PRI_WMASK [NUM_PRI] = '{
      16'hFFFF, 16'hFFF0, 16'hFFFF, 16'hFFFF, 16'hFFFF
   };

   // Status, enable, clear and control layout
   localparam int EV_W        = 2;
   localparam int EV_ACCEPT   = 0;
   localparam int EV_WAKE     = 1;
   localparam int CTRL_OSC32K = 0;

endpackage : prioritizer_pkg

/* prioritizer_sva.sv */
// Port-level checks for the interrupt prioritizer
module prioritizer_sva #(
   parameter int ADDR_W = 8
) (
   input wire logic                                clock_i,
   input wire logic                                rst_i,
   input wire logic                                psel_i,
   input wire logic                                penable_i,
   input wire logic [ADDR_W-1:0]                   paddr_i,
   input wire logic                                pready_o,
   input wire logic                                pslverr_o,
   input wire logic [prioritizer_pkg::NUM_SRC-1:0] src_req_i,
   input wire logic                                nmi_req_i,
   input wire logic [3:0]                          cpu_mask_level_i,
   input wire logic                                cpu_standby_i,
   input wire logic                                cpu_irq_req_o,
   input wire logic [prioritizer_pkg::LVL_W-1:0]   cpu_irq_level_o,
   input wire logic                                standby_wake_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   a_zero_wait: assert property (psel_i && penable_i |-> pready_o)
      else $error("access without ready");
   a_unmapped_err: assert property (psel_i && penable_i && paddr_i > 8'h28 |-> pslverr_o)
      else $error("unmapped access not refused");
   a_err_in_access: assert property (pslverr_o |-> psel_i && penable_i)
      else $error("error outside access phase");
   a_nmi_top: assert property (nmi_req_i |=> cpu_irq_req_o && cpu_irq_level_o == 5'h10)
      else $error("nmi not presented at level 16");
   a_debug_fixed: assert property (src_req_i[0] && !nmi_req_i && cpu_mask_level_i != 4'hF
      |=> cpu_irq_req_o && cpu_irq_level_o == 5'h0F)
      else $error("debug request not at level 15");
   a_above_mask: assert property (cpu_irq_req_o && !$past(nmi_req_i)
      |-> cpu_irq_level_o > {1'b0, $past(cpu_mask_level_i)})
      else $error("request not above mask");
   a_idle_quiet: assert property (src_req_i == '0 && !nmi_req_i
      |=> !cpu_irq_req_o && cpu_irq_level_o == 5'h00)
      else $error("request with no source");
   a_wake_cause: assert property (standby_wake_o |-> cpu_irq_req_o && $past(cpu_standby_i))
      else $error("wake without standby or request");
endmodule // prioritizer_sva

/* cpu_core_model.sv */
// Behavioural CPU core that takes a standing request after a chosen delay
module cpu_core_model (
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       irq_req_i,
   input  wire logic       take_en_i,
   input  wire logic [3:0] delay_i,
   output logic            accept_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_reg;
   // One-cycle pulse, only while a request stands
   always_ff @(posedge clock_i) begin
      if (rst_i || !irq_req_i || accept_o) begin
         wait_reg <= 4'h0;
         accept_o <= 1'b0;
      end else if (take_en_i && wait_reg == delay_i) begin
         accept_o <= 1'b1;
      end else begin
         wait_reg <= wait_reg + 4'h1;
      end
   end
endmodule // cpu_core_model

/* peripheral_interrupt_prioritizer_tb.sv */
// Self-checking bench for the interrupt prioritizer
module peripheral_interrupt_prioritizer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock_i, rst_i, psel, penable, pwrite, pready, pslverr, nmi, standby;
   logic        accept, irq_req, wake, irq, take_en;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [35:0] src;
   logic [3:0]  mask, delay;
   logic [4:0]  level;
   int          n_fail, checks_done, cycles;

   peripheral_interrupt_prioritizer dut (.clock_i, .rst_i, .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .src_req_i(src), .nmi_req_i(nmi),
      .cpu_mask_level_i(mask), .cpu_standby_i(standby), .cpu_accept_i(accept),
      .cpu_irq_req_o(irq_req), .cpu_irq_level_o(level), .standby_wake_o(wake), .irq_o(irq));
   cpu_core_model core (.clock_i, .rst_i, .irq_req_i(irq_req), .take_en_i(take_en),
      .delay_i(delay), .accept_o(accept));

   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end

   task automatic test_done;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // A hung handshake ends here rather than running forever
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         test_done();
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // For a read, d is the expected data
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      do @(posedge clock_i); while (pready !== 1'b1);
      if (!w) chk("prdata", d, prdata);
      chk("pslverr", 32'(e), 32'(pslverr));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic take(input logic [35:0] s, input logic n, input logic [11:0] ev, fx);
      int i;
      i = 0;
      src <= s;
      nmi <= n;
      take_en <= 1'b1;
      while (accept !== 1'b1 && i < 20) begin
         @(posedge clock_i);
         i++;
      end
      src <= '0;
      nmi <= 1'b0;
      take_en <= 1'b0;
      apb(0, prioritizer_pkg::ADDR_EVENT, {20'h0, ev}, 0);
      apb(0, prioritizer_pkg::ADDR_EVENT_FIX, {20'h0, fx}, 0);
   endtask

   initial begin
      {rst_i, psel, penable, pwrite, nmi, standby, take_en} = 7'h40;
      {paddr, pwdata, src, mask, delay} = '0;
      {n_fail, checks_done, cycles} = '0;
      repeat (8) @(posedge clock_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         apb(0, 8'(4 * i), 32'h0, 0);
         apb(1, 8'(4 * i), 32'hFFFF, 0);
         apb(0, 8'(4 * i), {16'h0, prioritizer_pkg::PRI_WMASK[i]}, 0);
         apb(1, 8'(4 * i), 32'h0, 0);
      end
      apb(0, 8'h2C, 32'h0, 1);
      apb(1, prioritizer_pkg::ADDR_EVENT, 32'h1, 1);
      apb(1, prioritizer_pkg::ADDR_PRI_A, 32'h5000, 0);
      apb(1, prioritizer_pkg::ADDR_CTRL, 32'h1, 0);
      apb(1, prioritizer_pkg::ADDR_INT_EN, 32'h3, 0);
      mask <= 4'h2;
      standby <= 1'b1;
      src <= 36'h000400000;
      repeat (2) @(posedge clock_i);
      chk("wake", 32'h1, 32'(wake));
      chk("level", 32'h5, 32'(level));
      apb(0, prioritizer_pkg::ADDR_INT_STAT, 32'h2, 0);
      apb(1, prioritizer_pkg::ADDR_CTRL, 32'h0, 0);
      repeat (2) @(posedge clock_i);
      chk("wake off", 32'h0, 32'(wake));
      mask <= 4'h5;
      repeat (2) @(posedge clock_i);
      chk("masked", 32'h0, 32'(irq_req));
      {standby, mask, src} <= {1'b0, 4'h2, 36'h4};
      apb(1, prioritizer_pkg::ADDR_INT_CLR, 32'h3, 0);
      // The clear lands at the access edge, so the status is seen one edge later
      @(posedge clock_i);
      chk("level zero", 32'h0, 32'(irq_req));
      chk("irq clear", 32'h0, 32'(irq));
      take(36'h000400000, 0, 12'h400, 12'h400);
      chk("irq", 32'h1, 32'(irq));
      delay <= 4'h3;
      apb(1, 8'h08, 32'h0007, 0);
      take(36'h000000002, 0, 12'h300, 12'h600);
      apb(1, prioritizer_pkg::ADDR_PRI_E, 32'h9000, 0);
      take(36'h000001200, 0, 12'h2C0, 12'h800);
      apb(1, prioritizer_pkg::ADDR_PRI_A, 32'hF000, 0);
      take(36'h000400001, 0, 12'h5E0, 12'h5E0);
      take(36'h000000001, 1, 12'h1C0, 12'h1C0);
      test_done();
   end
endmodule // peripheral_interrupt_prioritizer_tb

bind peripheral_interrupt_prioritizer prioritizer_sva #(.ADDR_W(ADDR_W)) sva (.clock_i, .rst_i,
   .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o, .src_req_i, .nmi_req_i,
   .cpu_mask_level_i, .cpu_standby_i, .cpu_irq_req_o, .cpu_irq_level_o, .standby_wake_o);
